/* File: core/rcf_interp_fir_modulator.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// input buffer
module rcf_fifo #(
	parameter int unsigned W = 32,
	parameter int unsigned D = 8
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	// fill side
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	// drain side
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int unsigned AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       rp;
		logic [AW-1:0]       wp;
		logic [AW:0]         cnt;
		logic                rdy;
	} rcf_fifo_s;
	rcf_fifo_s q, n;
	logic push, pop;

	assign in_ready  = q.rdy;
	assign out_valid = (q.cnt != '0);
	assign out_data  = q.mem[q.rp];

	always_comb begin
		n = q;
		push = in_valid && q.rdy;
		pop = out_valid && out_ready;
		if (push) begin
			n.mem[q.wp] = in_data;
			n.wp = q.wp + 1'b1;
		end
		if (pop) begin
			n.rp = q.rp + 1'b1;
		end
		n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		n.rdy = (n.cnt < (AW+1)'(D));
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.rdy <= 1'b1;
		end else begin
			q <= n;
		end
	end
endmodule

// ==========================================================
// filter stage
module rcf_interp_fir_modulator (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// microport
	input  wire logic [11:0] mp_addr,
	input  wire logic [17:0] mp_wdata,
	input  wire logic        mp_wr,
	input  wire logic        mp_rd,
	output logic      [17:0] mp_rdata,
	output logic             mp_rvalid,
	input  wire logic        prog_access,
	// serial port words
	input  wire logic        in_valid,
	input  wire logic [31:0] in_word,
	output logic             in_ready,
	// sync
	input  wire logic [3:0]  timeslot_sync_pins,
	input  wire logic        soft_sync,
	// to CIC interpolator
	output logic             out_valid,
	output logic      [17:0] out_i,
	output logic      [17:0] out_q
);
	typedef enum logic [2:0] {E_IDLE, E_MAC, E_FIN, E_APE, E_OUT, E_TAB} rcf_eng_e;
	typedef enum logic [2:0] {R_RUN, R_HOLDOFF, R_DOWN, R_QUIET, R_UP} rcf_ramp_e;
	typedef struct packed {
		rcf_eng_e              eng;
		rcf_ramp_e             rmp;
		logic [7:0]            nm1;
		logic [7:0]            offset;
		logic [9:0]            ctrl;
		logic [9:0]            ctrl_act;
		logic [7:0]            scfg;
		logic [7:0]            scfg_act;
		logic [15:0]           scale;
		logic [15:0]           scale_act;
		logic [17:0]           hold;
		logic [15:0]           ape1;
		logic [15:0]           ape2;
		logic [7:0][15:0]      ramp;
		logic [255:0][15:0]    coef;
		logic [31:0][15:0]     smp;
		logic [3:0]            wp;
		logic [3:0]            tap;
		logic [8:0]            cidx;
		logic                  sub;
		logic [1:0]            apec;
		logic                  tabm;
		logic [3:0]            rot;
		logic signed [21:0]    acc_i;
		logic signed [21:0]    acc_q;
		logic [17:0]           y_i;
		logic [17:0]           y_q;
		logic [17:0]           tab_i;
		logic [17:0]           tab_q;
		logic [3:0][17:0]      hi;
		logic [3:0][17:0]      hq;
		logic [15:0]           hcnt;
		logic [2:0]            ridx;
		logic [3:0]            s1;
		logic [3:0]            s2;
		logic [3:0]            s3;
		logic [3:0]            lvl;
		logic [17:0]           rdata;
		logic                  rvalid;
		logic                  out_v;
		logic [17:0]           oi;
		logic [17:0]           oq;
	} rcf_top_s;
	rcf_top_s q, n;

	logic        f_valid, f_pop;
	logic [31:0] w;

	assign mp_rdata  = q.rdata;
	assign mp_rvalid = q.rvalid;
	assign out_valid = q.out_v;
	assign out_i     = q.oi;
	assign out_q     = q.oq;

	rcf_fifo #(
		.W (rcf_pkg::WORD_W),
		.D (rcf_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_valid  (in_valid),
		.in_data   (in_word),
		.in_ready  (in_ready),
		.out_valid (f_valid),
		.out_data  (w),
		.out_ready (f_pop)
	);

	// programming stops the engine taking new words; a word in progress still runs on to idle
	assign f_pop = f_valid && !prog_access && (q.eng == E_IDLE);

	logic [2:0]         mode;
	logic [3:0]         taps, ph, k;
	logic [15:0]        vi, vq, rv, g;
	logic [11:0]        soff;
	logic               ape_en, table_mode, step, sync_evt;
	logic signed [17:0] ma;
	logic signed [15:0] mb;
	logic signed [33:0] mprod;
	logic signed [21:0] prod, nacc, nacc_q;
	logic [31:0]        gp;
	logic signed [34:0] sp_i, sp_q;
	logic [4:0]         shamt;
	logic [3:0]         rise;

	always_comb begin
		n = q;
		n.out_v = 1'b0;
		n.rvalid = 1'b0;
		mode = q.ctrl_act[rcf_pkg::CTRL_MODE_LSB +: 3];
		taps = q.ctrl_act[rcf_pkg::CTRL_TAPS_LSB +: 4];
		ape_en = q.scfg_act[rcf_pkg::SCFG_APE_BIT];
		soff = mp_addr - rcf_pkg::SMP_LO;
		k = q.wp - 4'h1 - q.tap;
		ma = '0;
		mb = '0;
		nacc = '0;
		nacc_q = '0;
		ph = q.rot;

		// ======================================================
		// microport
		if (mp_wr) begin
			case (mp_addr)
				rcf_pkg::REG_IMPULSE: n.nm1 = mp_wdata[7:0];
				rcf_pkg::REG_OFFSET: n.offset = mp_wdata[7:0];
				rcf_pkg::REG_CTRL: n.ctrl = mp_wdata[9:0];
				rcf_pkg::REG_SCFG: n.scfg = mp_wdata[7:0];
				rcf_pkg::REG_SCALE: n.scale = mp_wdata[15:0];
				rcf_pkg::REG_HOLD: n.hold = mp_wdata;
				rcf_pkg::REG_APE1: n.ape1 = mp_wdata[15:0];
				rcf_pkg::REG_APE2: n.ape2 = mp_wdata[15:0];
				default: begin
					if (mp_addr >= rcf_pkg::RAMP_LO && mp_addr <= rcf_pkg::RAMP_HI) begin
						n.ramp[mp_addr[2:0]] = mp_wdata[15:0];
					end
					if (prog_access && mp_addr >= rcf_pkg::SMP_LO
						&& mp_addr <= rcf_pkg::SMP_HI) begin
						n.smp[soff[4:0]] = mp_wdata[15:0];
					end
					if (prog_access && mp_addr >= rcf_pkg::COEF_LO
						&& mp_addr <= rcf_pkg::COEF_HI) begin
						n.coef[mp_addr[7:0]] = mp_wdata[15:0];
					end
				end
			endcase
		end
		if (mp_rd) begin
			n.rvalid = 1'b1;
			case (mp_addr)
				rcf_pkg::REG_IMPULSE: n.rdata = {10'h000, q.nm1};
				rcf_pkg::REG_OFFSET: n.rdata = {10'h000, q.offset};
				rcf_pkg::REG_CTRL: n.rdata = {8'h00, q.ctrl};
				rcf_pkg::REG_SCFG: n.rdata = {10'h000, q.scfg};
				rcf_pkg::REG_SCALE: n.rdata = {2'h0, q.scale};
				rcf_pkg::REG_HOLD: n.rdata = q.hold;
				rcf_pkg::REG_APE1: n.rdata = {2'h0, q.ape1};
				rcf_pkg::REG_APE2: n.rdata = {2'h0, q.ape2};
				rcf_pkg::REG_STATUS: n.rdata = {8'h00, q.wp, q.rmp, q.eng};
				default: begin
					n.rdata = '0;
					if (mp_addr >= rcf_pkg::RAMP_LO && mp_addr <= rcf_pkg::RAMP_HI) begin
						n.rdata = {2'h0, q.ramp[mp_addr[2:0]]};
					end
					if (prog_access && mp_addr >= rcf_pkg::SMP_LO
						&& mp_addr <= rcf_pkg::SMP_HI) begin
						n.rdata = {2'h0, q.smp[soff[4:0]]};
					end
					if (prog_access && mp_addr >= rcf_pkg::COEF_LO
						&& mp_addr <= rcf_pkg::COEF_HI) begin
						n.rdata = {2'h0, q.coef[mp_addr[7:0]]};
					end
				end
			endcase
		end

		// mode and scale take effect only while silent or programming
		if (prog_access || q.rmp == R_QUIET) begin
			n.ctrl_act = q.ctrl;
			n.scfg_act = q.scfg;
			n.scale_act = q.scale;
		end

		// ======================================================
		// input decode
		case (mode)
			rcf_pkg::MODE_DQPSK: ph = q.rot + {w[1:0], 2'b10};
			rcf_pkg::MODE_8PSK: ph = {w[2:0], 1'b0};
			rcf_pkg::MODE_ROT8PSK: ph = {w[2:0], 1'b0} + q.rot;
			rcf_pkg::MODE_GMSK, rcf_pkg::MODE_MSK: ph = q.rot + (w[0] ? 4'h4 : 4'hC);
			rcf_pkg::MODE_QPSK: ph = {w[1:0], 2'b10};
			default: ph = q.rot;
		endcase
		case (mode)
			rcf_pkg::MODE_FIR: begin
				vi = w[31:16];
				vq = w[15:0];
			end
			rcf_pkg::MODE_COMPACT: begin
				// short words are left-justified, low bits zero
				if (q.ctrl_act[rcf_pkg::CTRL_WIDE_BIT]) begin
					vi = {w[23:12], 4'h0};
					vq = {w[11:0], 4'h0};
				end else begin
					vi = {w[15:8], 8'h00};
					vq = {w[7:0], 8'h00};
				end
			end
			default: begin
				vi = rcf_pkg::rcf_cos(ph);
				vq = rcf_pkg::rcf_cos(ph - 4'h4);
			end
		endcase
		table_mode = (mode == rcf_pkg::MODE_GMSK) || (mode == rcf_pkg::MODE_MSK)
			|| (mode == rcf_pkg::MODE_QPSK);

		// ======================================================
		// shared multiplier operands
		case (q.eng)
			E_MAC: begin
				ma = $signed({q.smp[{k, q.sub}], 2'b00});
				mb = $signed(q.coef[q.offset + q.cidx[7:0]]);
			end
			E_APE: begin
				if (!q.apec[0]) begin
					ma = $signed(rcf_pkg::rcf_clip(22'(q.apec[1] ? $signed(q.y_q) : $signed(q.y_i))
						- 22'($signed(q.apec[1] ? q.hq[3] : q.hi[3]))));
					mb = $signed(q.ape2);
				end else begin
					ma = $signed(rcf_pkg::rcf_clip(22'($signed(q.apec[1] ? q.hq[0] : q.hi[0]))
						- 22'($signed(q.apec[1] ? q.hq[2] : q.hi[2]))));
					mb = $signed(q.ape1);
				end
			end
			default: begin
				ma = '0;
				mb = '0;
			end
		endcase
		mprod = ma * mb;
		prod = 22'($signed(mprod[33:rcf_pkg::PROD_LSB]));

		// ======================================================
		// ramp gain
		case (q.rmp)
			R_DOWN, R_UP: rv = q.ramp[q.ridx];
			R_QUIET: rv = 16'h0000;
			default: rv = q.ramp[rcf_pkg::RAMP_WORDS-1];
		endcase
		gp = q.scale_act * rv;
		g = gp[31:16];
		shamt = 5'(rcf_pkg::GAIN_SHIFT) + {3'h0, q.scfg_act[rcf_pkg::SCFG_COARSE_LSB +: 2]};
		sp_i = $signed(q.y_i) * $signed({1'b0, g});
		sp_q = $signed(q.y_q) * $signed({1'b0, g});
		step = (q.eng == E_OUT);

		// ======================================================
		// engine
		case (q.eng)
			E_IDLE: begin
				if (f_pop) begin
					n.rot = (mode == rcf_pkg::MODE_ROT8PSK) ? q.rot + rcf_pkg::ROT_STEP : ph;
					n.cidx = '0;
					n.sub = 1'b0;
					n.tap = '0;
					n.acc_i = '0;
					n.acc_q = '0;
					n.tabm = table_mode;
					if (table_mode) begin
						n.tab_i = {vi, 2'b00};
						n.tab_q = {vq, 2'b00};
						n.eng = E_TAB;
					end else begin
						n.smp[{q.wp, 1'b0}] = vi;
						n.smp[{q.wp, 1'b1}] = vq;
						n.wp = q.wp + 4'h1;
						n.eng = E_MAC;
					end
				end
			end
			E_MAC: begin
				// only the taps of this phase: stuffed zeros cost nothing
				n.sub = !q.sub;
				if (!q.sub) begin
					n.acc_i = q.acc_i + prod;
				end else begin
					n.acc_q = q.acc_q + prod;
					n.tap = q.tap + 4'h1;
					n.cidx = q.cidx + 9'h001;
					if (q.tap == taps) begin
						n.eng = E_FIN;
					end
				end
			end
			E_FIN: begin
				n.y_i = rcf_pkg::rcf_clip(q.acc_i >>> 1);
				n.y_q = rcf_pkg::rcf_clip(q.acc_q >>> 1);
				n.acc_i = '0;
				n.acc_q = '0;
				n.apec = '0;
				n.eng = ape_en ? E_APE : E_OUT;
			end
			E_APE: begin
				n.apec = q.apec + 2'h1;
				nacc = q.acc_i + prod;
				nacc_q = q.acc_q + prod;
				if (q.apec[1]) begin
					n.acc_q = nacc_q;
				end else begin
					n.acc_i = nacc;
				end
				if (q.apec == 2'h3) begin
					n.y_i = rcf_pkg::rcf_clip((q.acc_i + 22'($signed({q.hi[1], 1'b0}))) >>> 1);
					n.y_q = rcf_pkg::rcf_clip((nacc_q + 22'($signed({q.hq[1], 1'b0}))) >>> 1);
					n.hi = {q.hi[2], n.y_i, q.hi[0], q.y_i};
					n.hq = {q.hq[2], n.y_q, q.hq[0], q.y_q};
					n.eng = E_OUT;
				end
			end
			E_OUT: begin
				n.out_v = 1'b1;
				n.oi = rcf_pkg::rcf_clip(22'(sp_i >>> shamt));
				n.oq = rcf_pkg::rcf_clip(22'(sp_q >>> shamt));
				n.tap = '0;
				n.sub = 1'b0;
				n.acc_i = '0;
				n.acc_q = '0;
				// next phase until the impulse length is used up
				if (q.cidx <= {1'b0, q.nm1}) begin
					n.eng = q.tabm ? E_TAB : E_MAC;
				end else begin
					n.eng = E_IDLE;
				end
			end
			E_TAB: begin
				n.sub = !q.sub;
				if (q.sub) begin
					n.y_i = q.tab_i;
					n.y_q = q.tab_q;
					n.cidx = q.cidx + {5'h00, taps} + 9'h001;
					n.apec = '0;
					n.eng = ape_en ? E_APE : E_OUT;
				end
			end
			default: n.eng = E_IDLE;
		endcase

		// ======================================================
		// sync and ramp sequencer
		n.s1 = timeslot_sync_pins;
		n.s2 = q.s1;
		n.s3 = q.s2;
		n.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 | q.s3));
		rise = q.s2 & q.s3 & ~q.lvl;
		sync_evt = rise[q.hold[rcf_pkg::HOLD_SEL_LSB +: 2]] || soft_sync;
		case (q.rmp)
			R_RUN: begin
				if (sync_evt) begin
					n.hcnt = q.hold[15:0];
					n.rmp = R_HOLDOFF;
				end
			end
			R_HOLDOFF: begin
				if (q.hcnt == 16'h0000) begin
					n.ridx = 3'(rcf_pkg::RAMP_WORDS - 1);
					n.rmp = R_DOWN;
				end else begin
					n.hcnt = q.hcnt - 16'h0001;
				end
			end
			R_DOWN: begin
				if (step) begin
					if (q.ridx == 3'h0) begin
						n.rmp = R_QUIET;
					end else begin
						n.ridx = q.ridx - 3'h1;
					end
				end
			end
			R_QUIET: begin
				if (step) begin
					n.rmp = R_UP;
				end
			end
			R_UP: begin
				if (step) begin
					if (q.ridx == 3'(rcf_pkg::RAMP_WORDS - 1)) begin
						n.rmp = R_RUN;
					end else begin
						n.ridx = q.ridx + 3'h1;
					end
				end
			end
			default: n.rmp = R_RUN;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.scale <= rcf_pkg::RST_SCALE;
			q.scale_act <= rcf_pkg::RST_SCALE;
			q.ramp <= {rcf_pkg::RAMP_WORDS{rcf_pkg::RST_RAMP}};
		end else begin
			q <= n;
		end
	end

	// ==========================================================
	// checks
	AST_OUT_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		out_valid |=> !out_valid)
		else $error("output valid longer than one cycle");
	AST_PROG_FREEZE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(prog_access && q.eng == E_IDLE) |=> (q.eng == E_IDLE))
		else $error("engine left idle while programming");
	AST_MAC_TWO: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(q.eng == E_MAC && !q.sub) |=> (q.eng == E_MAC && q.sub))
		else $error("tap did not take two cycles");
	AST_APE_FOUR: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(q.eng == E_FIN && ape_en) |=> (q.eng == E_APE)[*4] ##1 (q.eng == E_OUT))
		else $error("equaliser did not take four cycles");
	AST_NO_APE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(q.eng == E_FIN && !ape_en) |=> (q.eng == E_OUT) ##1 out_valid)
		else $error("bypassed equaliser delayed output");
	AST_TAPS: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(q.eng == E_MAC) |-> (q.tap <= taps))
		else $error("tap index past taps per phase");
	AST_QUIET_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(q.eng == E_OUT && q.rmp == R_QUIET) |=> (out_valid && out_i == '0 && out_q == '0))
		else $error("output not silent during pause");
	AST_TAB_BYPASS: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(f_pop && table_mode) |=> (q.eng == E_TAB) ##2 (q.eng != E_MAC))
		else $error("table mode entered the filter");
	AST_CFG_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$changed(q.ctrl_act) |-> ($past(prog_access) || ($past(q.rmp) == R_QUIET)))
		else $error("mode changed while output active");
endmodule

`default_nettype wire

/* File: core/rcf_pkg.sv */
package rcf_pkg;

	// ==========================================================
	// widths and sizes
	localparam int unsigned ADDR_W     = 12;
	localparam int unsigned DATA_W     = 18;
	localparam int unsigned WORD_W     = 32;
	localparam int unsigned OUT_W      = 18;
	localparam int unsigned ACC_W      = 22;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned COEF_WORDS = 256;
	localparam int unsigned SMP_WORDS  = 32;
	localparam int unsigned RAMP_WORDS = 8;
	localparam int unsigned PROD_LSB   = 14;
	localparam int unsigned GAIN_SHIFT = 14;

	// ==========================================================
	// channel register offsets
	localparam logic [11:0] REG_IMPULSE = 12'h00A;
	localparam logic [11:0] REG_OFFSET  = 12'h00B;
	localparam logic [11:0] REG_CTRL    = 12'h00C;
	localparam logic [11:0] REG_SCFG    = 12'h00D;
	localparam logic [11:0] REG_SCALE   = 12'h00E;
	localparam logic [11:0] REG_HOLD    = 12'h00F;
	localparam logic [11:0] REG_APE1    = 12'h110;
	localparam logic [11:0] REG_APE2    = 12'h111;
	localparam logic [11:0] REG_STATUS  = 12'h130;
	localparam logic [11:0] RAMP_LO     = 12'h120;
	localparam logic [11:0] RAMP_HI     = 12'h127;
	localparam logic [11:0] SMP_LO      = 12'h020;
	localparam logic [11:0] SMP_HI      = 12'h05F;
	localparam logic [11:0] COEF_LO     = 12'h800;
	localparam logic [11:0] COEF_HI     = 12'h8FF;

	// ==========================================================
	// field positions
	localparam int unsigned CTRL_TAPS_LSB   = 0;
	localparam int unsigned CTRL_MODE_LSB   = 4;
	localparam int unsigned CTRL_WIDE_BIT   = 9;
	localparam int unsigned SCFG_APE_BIT    = 5;
	localparam int unsigned SCFG_COARSE_LSB = 6;
	localparam int unsigned HOLD_SEL_LSB    = 16;

	// ==========================================================
	// processing modes
	localparam logic [2:0] MODE_FIR     = 3'h0;
	localparam logic [2:0] MODE_DQPSK   = 3'h1;
	localparam logic [2:0] MODE_GMSK    = 3'h2;
	localparam logic [2:0] MODE_MSK     = 3'h3;
	localparam logic [2:0] MODE_COMPACT = 3'h4;
	localparam logic [2:0] MODE_8PSK    = 3'h5;
	localparam logic [2:0] MODE_ROT8PSK = 3'h6;
	localparam logic [2:0] MODE_QPSK    = 3'h7;

	// ==========================================================
	// reset values and rotation step
	localparam logic [15:0] RST_SCALE = 16'h4000;
	localparam logic [15:0] RST_RAMP  = 16'hFFFF;
	localparam logic [3:0]  ROT_STEP  = 4'h3;

	// cosine of k*pi/8 in 1.15
	function automatic logic [15:0] rcf_cos(input logic [3:0] k);
		logic [15:0] c;
		case (k)
			4'h0: c = 16'h7FFF;
			4'h1, 4'hF: c = 16'h7642;
			4'h2, 4'hE: c = 16'h5A82;
			4'h3, 4'hD: c = 16'h30FC;
			4'h5, 4'hB: c = 16'hCF04;
			4'h6, 4'hA: c = 16'hA57E;
			4'h7, 4'h9: c = 16'h89BE;
			4'h8: c = 16'h8001;
			default: c = 16'h0000;
		endcase
		return c;
	endfunction

	// clip a 22-bit value to the 18-bit range
	function automatic logic [17:0] rcf_clip(input logic signed [21:0] v);
		logic [17:0] r;
		if (v > 22'sh01FFFF) begin
			r = 18'h1FFFF;
		end else if (v < -22'sh020000) begin
			r = 18'h20000;
		end else begin
			r = v[17:0];
		end
		return r;
	endfunction

endpackage

/* File: test/rcf_partner.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// serial port source and CIC sink
module rcf_partner (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// serial port side
	input  wire logic        in_ready,
	output logic             in_valid,
	output logic      [31:0] in_word,
	// CIC side
	input  wire logic        out_valid,
	input  wire logic [17:0] out_i,
	input  wire logic [17:0] out_q
);
	logic [17:0] cap_i [64];
	logic [17:0] cap_q [64];
	int          cap_t [64];
	int          n_out = 0;
	int          cyc = 0;
	logic        stall_err = 1'b0;

	initial begin
		in_valid = 1'b0;
		in_word  = 32'h0;
	end

	// the CIC never stalls, so every strobe is one sample
	always @(posedge clk_sys) begin
		cyc = cyc + 1;
		if (rst_n && out_valid === 1'b1) begin
			cap_i[n_out % 64] = out_i;
			cap_q[n_out % 64] = out_q;
			cap_t[n_out % 64] = cyc;
			n_out = n_out + 1;
		end
	end

	// word held until in_ready was high at the taking edge
	task automatic send(input logic [31:0] w);
		int k;
		@(negedge clk_sys);
		in_valid = 1'b1;
		in_word  = w;
		k = 0;
		while (in_ready !== 1'b1 && k < 200) begin
			@(negedge clk_sys);
			k++;
		end
		if (k >= 200) stall_err = 1'b1;
		@(negedge clk_sys);
		in_valid = 1'b0;
		// released line shows the inverse, not a stale copy
		in_word  = ~w;
	endtask
endmodule

`default_nettype wire

/* File: test/test_rcf_interp_fir_modulator.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// testbench
module test_rcf_interp_fir_modulator;
	logic        clk_sys = 1'b0;
	logic        rst_n;
	logic [11:0] mp_addr;
	logic [17:0] mp_wdata;
	logic        mp_wr;
	logic        mp_rd;
	logic [17:0] mp_rdata;
	logic        mp_rvalid;
	logic        prog_access;
	logic        in_valid;
	logic [31:0] in_word;
	logic        in_ready;
	logic        out_valid;
	logic [17:0] out_i;
	logic [17:0] out_q;
	logic [3:0]  sync_pins;
	logic        soft_sync;
	int          n_mismatch = 0;
	int          num_checks = 0;

	always #5 clk_sys = ~clk_sys;

	rcf_interp_fir_modulator i_rcf_interp_fir_modulator (
		.clk_sys(clk_sys), .rst_n(rst_n), .mp_addr(mp_addr), .mp_wdata(mp_wdata),
		.mp_wr(mp_wr), .mp_rd(mp_rd), .mp_rdata(mp_rdata), .mp_rvalid(mp_rvalid),
		.prog_access(prog_access), .in_valid(in_valid), .in_word(in_word),
		.in_ready(in_ready), .timeslot_sync_pins(sync_pins), .soft_sync(soft_sync),
		.out_valid(out_valid), .out_i(out_i), .out_q(out_q)
	);

	rcf_partner i_rcf_partner (
		.clk_sys(clk_sys), .rst_n(rst_n), .in_ready(in_ready), .in_valid(in_valid),
		.in_word(in_word), .out_valid(out_valid), .out_i(out_i), .out_q(out_q)
	);

	task automatic wrap_up();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// tolerance covers the ramp table's 0xFFFF gain
	task automatic chk(input logic [17:0] seen, input logic [17:0] exp, input int tol);
		int d;
		num_checks++;
		d = int'($signed(seen)) - int'($signed(exp));
		if ($isunknown(seen) || d > tol || d < -tol) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [17:0] d);
		@(negedge clk_sys);
		mp_addr  = a;
		mp_wdata = d;
		mp_wr    = 1'b1;
		@(negedge clk_sys);
		mp_wr    = 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [17:0] e);
		@(negedge clk_sys);
		mp_addr = a;
		mp_rd   = 1'b1;
		@(negedge clk_sys);
		mp_rd   = 1'b0;
		chk({17'h0, mp_rvalid}, 18'h1, 0);
		chk(mp_rdata, e, 0);
	endtask

	// active copies only load while programming or while the ramp is quiet
	task automatic cfg(input logic [17:0] off, input logic [17:0] ctl, input logic [17:0] sc);
		prog_access = 1'b1;
		wr(rcf_pkg::REG_OFFSET, off);
		wr(rcf_pkg::REG_IMPULSE, 18'h1);
		wr(rcf_pkg::REG_CTRL, ctl);
		wr(rcf_pkg::REG_SCFG, sc);
		// one more edge so the last write reaches the active copy
		@(negedge clk_sys);
		prog_access = 1'b0;
	endtask

	task automatic await(input int n);
		int k;
		k = 0;
		while (i_rcf_partner.n_out < n && k < 400) begin
			@(negedge clk_sys);
			k++;
		end
		if (k >= 400) begin
			n_mismatch++;
			wrap_up();
		end
		repeat (12) @(negedge clk_sys);
		chk(18'(i_rcf_partner.n_out), 18'(n), 0);
	endtask

	task automatic run(input logic [31:0] w, input int n);
		i_rcf_partner.n_out = 0;
		i_rcf_partner.send(w);
		await(n);
	endtask

	initial begin
		rst_n       = 1'b0;
		mp_addr     = 12'h0;
		mp_wdata    = 18'h0;
		mp_wr       = 1'b0;
		mp_rd       = 1'b0;
		prog_access = 1'b0;
		sync_pins   = 4'h0;
		soft_sync   = 1'b0;
		repeat (3) @(negedge clk_sys);
		rst_n = 1'b1;
		rd(rcf_pkg::REG_SCALE, {2'h0, rcf_pkg::RST_SCALE});
		rd(rcf_pkg::REG_OFFSET, 18'h0);
		wr(rcf_pkg::REG_OFFSET, 18'h3A5);
		rd(rcf_pkg::REG_OFFSET, 18'h0A5);
		rd(12'h3FF, 18'h0);
		wr(rcf_pkg::SMP_LO, 18'h1234);
		rd(rcf_pkg::SMP_LO, 18'h0);
		prog_access = 1'b1;
		wr(rcf_pkg::SMP_LO, 18'h1234);
		rd(rcf_pkg::SMP_LO + 12'h020, 18'h1234);
		for (int i = 0; i < 32; i++) wr(rcf_pkg::SMP_LO + 12'(i), 18'h0);
		rd(rcf_pkg::SMP_LO, 18'h0);
		// decoy filter at 0; coefficients per phase
		wr(rcf_pkg::COEF_LO, 18'h08000);
		wr(rcf_pkg::COEF_LO + 12'h001, 18'h08000);
		wr(rcf_pkg::COEF_LO + 12'h010, 18'h04000);
		wr(rcf_pkg::COEF_LO + 12'h011, 18'h02000);
		cfg(18'h10, 18'h0, 18'h0);
		run(32'h4000_2000, 2);
		chk(i_rcf_partner.cap_i[0], 18'h08000, 4);
		chk(i_rcf_partner.cap_q[0], 18'h04000, 4);
		chk(i_rcf_partner.cap_i[1], 18'h04000, 4);
		chk(i_rcf_partner.cap_q[1], 18'h02000, 4);
		chk(18'(i_rcf_partner.cap_t[1] - i_rcf_partner.cap_t[0]), 18'h4, 0);
		run(32'h8000_7FFF, 2);
		chk(i_rcf_partner.cap_i[0], 18'h30000, 4);
		chk(i_rcf_partner.cap_q[0], 18'h0FFFE, 4);
		// narrow words padded with zeros, 16 and 24 bit forms
		cfg(18'h10, 18'h040, 18'h0);
		run(32'h0000_40C0, 2);
		chk(i_rcf_partner.cap_i[0], 18'h08000, 4);
		chk(i_rcf_partner.cap_q[0], 18'h38000, 4);
		cfg(18'h10, 18'h240, 18'h0);
		run(32'h0040_0C00, 2);
		chk(i_rcf_partner.cap_i[0], 18'h08000, 4);
		chk(i_rcf_partner.cap_q[0], 18'h38000, 4);
		// every remaining mode yields L outputs per symbol
		for (int m = 1; m < 8; m++) begin
			if (m != 4) begin
				cfg(18'h10, 18'(m) << 4, 18'h0);
				run(32'h1, 2);
				if (m == 5) chk(i_rcf_partner.cap_i[0], 18'h0B504, 4);
				// table vector 0x16A08 trimmed by the near-unity gain
				if (m == 7) chk(i_rcf_partner.cap_q[0], 18'h16A02, 4);
			end
		end
		// two taps of -1 times -1 must clip
		cfg(18'h0, 18'h1, 18'h0);
		i_rcf_partner.send(32'h8000_8000);
		run(32'h8000_8000, 2);
		// clipped to 0x1FFFF, then the 0xFFFF ramp gain trims a few codes
		chk(i_rcf_partner.cap_i[1], 18'h1FFF7, 4);
		// one idle cycle to fetch the next word
		chk(18'(i_rcf_partner.cap_t[1] - i_rcf_partner.cap_t[0]), 18'h7, 0);
		// buffer fills while frozen, then drains
		cfg(18'h10, 18'h0, 18'h0);
		prog_access = 1'b1;
		i_rcf_partner.n_out = 0;
		repeat (8) i_rcf_partner.send(32'h4000_2000);
		chk({17'h0, in_ready}, 18'h0, 0);
		chk(18'(i_rcf_partner.n_out), 18'h0, 0);
		prog_access = 1'b0;
		await(16);
		chk(i_rcf_partner.cap_i[15], 18'h04000, 4);
		chk({17'h0, in_ready}, 18'h1, 0);
		// pin sync: down, one silent sample, up at the new scale
		wr(rcf_pkg::RAMP_LO + 12'h003, 18'h08000);
		wr(rcf_pkg::REG_SCALE, 18'h02000);
		sync_pins = 4'h1;
		i_rcf_partner.n_out = 0;
		repeat (10) i_rcf_partner.send(32'h4000_2000);
		await(20);
		sync_pins = 4'h0;
		chk(i_rcf_partner.cap_i[1], 18'h04000, 4);
		chk(i_rcf_partner.cap_i[4], 18'h04000, 4);
		chk(i_rcf_partner.cap_i[8], 18'h00000, 0);
		chk(i_rcf_partner.cap_i[12], 18'h02000, 4);
		chk(i_rcf_partner.cap_i[18], 18'h04000, 4);
		// a soft_sync pulse starts the same sequence
		soft_sync = 1'b1;
		@(negedge clk_sys);
		soft_sync = 1'b0;
		i_rcf_partner.n_out = 0;
		repeat (9) i_rcf_partner.send(32'h4000_2000);
		await(18);
		chk(i_rcf_partner.cap_q[8], 18'h00000, 0);
		// equaliser borrows four multiplier cycles per output
		cfg(18'h10, 18'h0, 18'h20);
		run(32'h4000_2000, 2);
		chk(18'(i_rcf_partner.cap_t[1] - i_rcf_partner.cap_t[0]), 18'h8, 0);
		chk({17'h0, i_rcf_partner.stall_err}, 18'h0, 0);
		wrap_up();
	end
endmodule

`default_nettype wire
